// File: verilog/ovq_pkg.sv
`default_nettype none
package ovq_pkg;
   // ----------------------------------------------------------------
   // Clock and times
   // ----------------------------------------------------------------
   localparam int CLK_MHZ         = 100;
   localparam int DBNC_SHORT_US   = 10;
   localparam int DBNC_MID_US     = 100;
   localparam int DBNC_LONG_US    = 1000;
   localparam int FUSE_LOAD_US    = 500;
   localparam int SELF_TEST_US    = 500;
   localparam int PON_DBNC_US     = 20;
   localparam int DBNC_SHORT_CYC  = DBNC_SHORT_US * CLK_MHZ;
   localparam int DBNC_MID_CYC    = DBNC_MID_US * CLK_MHZ;
   localparam int DBNC_LONG_CYC   = DBNC_LONG_US * CLK_MHZ;
   localparam int FUSE_LOAD_CYC   = FUSE_LOAD_US * CLK_MHZ;
   localparam int SELF_TEST_CYC   = SELF_TEST_US * CLK_MHZ;
   localparam int PON_DBNC_CYC    = PON_DBNC_US * CLK_MHZ;
   localparam int CNT_W           = 20;

   // ----------------------------------------------------------------
   // Register map
   // ----------------------------------------------------------------
   localparam logic [3:0] CTRL_OFS   = 4'h0;
   localparam logic [3:0] STATUS_OFS = 4'h4;
   localparam int CTRL_EN_BIT        = 0;
   localparam int CTRL_SDWN_BIT      = 1;
   localparam int CTRL_DBNC_LSB      = 2;
   localparam int CTRL_LPDIS_BIT     = 4;
   localparam int STAT_OVFLAG_BIT    = 0;
   localparam int STAT_FUSE_BIT      = 1;
   localparam int STAT_TEST_BIT      = 2;
   localparam int STAT_OVLVL_BIT     = 3;
   localparam int STAT_STATE_LSB     = 4;

   localparam logic [1:0] DBNC_SHORT = 2'h0;
   localparam logic [1:0] DBNC_MID   = 2'h1;
   localparam logic [1:0] DBNC_LONG  = 2'h2;

   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      ST_UNPOWERED = 3'h0,
      ST_FUSE_LOAD = 3'h1,
      ST_OFF       = 3'h3,
      ST_SELF_TEST = 3'h2,
      ST_START     = 3'h6,
      ST_RUN       = 3'h7,
      ST_POWER_DN  = 3'h5
   } ovq_mode_t;

   typedef struct packed {
      ovq_mode_t           mode;
      logic [CNT_W-1:0]    cnt;
      logic [CNT_W-1:0]    ov_cnt;
      logic [CNT_W-1:0]    pon_cnt;
      logic                pon_armed;
      logic                pin_prev;
      logic                uv_prev;
      logic                ov_hit;
      logic                mon_en;
      logic                sdwn_sel;
      logic [1:0]          dbnc_sel;
      logic                lp_dis;
      logic                fuse_sdwn_def;
      logic                ov_flag;
      logic                fuse_done;
      logic                test_done;
      logic                first_slot;
      logic                pwr_down;
      logic                wreq;
      logic [31:0]         rdata;
   } ovq_state_t;
endpackage
`default_nettype wire

// File: verilog/ovq_qualifier.sv
// Function
// - Shutdown select 0: debounced overvoltage raises interrupt, device stays powered.
// - Shutdown select 1: debounced overvoltage starts power down sequence.
// - Monitor enable 0 disables overvoltage events; 1 enables them.
// - Monitor enable and shutdown select load from fuse defaults at power up.
// - Fuse shutdown default 0: overvoltage during power up only interrupts.
// - Fuse shutdown default 1: overvoltage aborts power up, back to off.
// - Debounce code 00=10us, 01=100us, 10=1000us, 11 reserved.
// - Debounce select loads from fuse default field at power up.
// - Pin high: power up sequence begins within 1.5 ms of supply crossing.
// - Pin high: self-test done within 1.4 ms of crossing, only on pass.
// - First sequence slot starts within 100 us of self-test done.
// - Each rising undervoltage crossing clears low-power off disable bit.
// - Software may change disable bit in run; held until next crossing.
// - Fuse load done within 600 us of crossing when fuses load fine.
// - From low-power off, self-test done within 700 us of pin high.
// - Level mode: pin high is power up event while off.
// - Edge mode: event after high-to-low edge held low for debounce time.
// - Power up accepted only with supply, thermal and error flags good; overvoltage blocks only when monitored with fuse shutdown default 1.
//
// Decided for this implementation: the address map and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module ovq_qualifier #(
   parameter int DBNC_SHORT_CYC = ovq_pkg::DBNC_SHORT_CYC,
   parameter int DBNC_MID_CYC   = ovq_pkg::DBNC_MID_CYC,
   parameter int DBNC_LONG_CYC  = ovq_pkg::DBNC_LONG_CYC,
   parameter int FUSE_LOAD_CYC  = ovq_pkg::FUSE_LOAD_CYC,
   parameter int SELF_TEST_CYC  = ovq_pkg::SELF_TEST_CYC,
   parameter int PON_DBNC_CYC   = ovq_pkg::PON_DBNC_CYC
) (
   input  wire logic        clk_in,
   input  wire logic        rstn_in,
   // Avalon-MM slave
   input  wire logic [3:0]  avs_address_in,
   input  wire logic        avs_read_in,
   input  wire logic        avs_write_in,
   input  wire logic [31:0] avs_writedata_in,
   input  wire logic [3:0]  avs_byteenable_in,
   output var  logic [31:0] avs_readdata_out,
   output var  logic        avs_waitrequest_out,
   // Comparators, flags and fuses
   input  wire logic        undervoltage_ok_in,
   input  wire logic        overvoltage_cmp_in,
   input  wire logic        thermal_shutdown_in,
   input  wire logic        trim_error_flag_in,
   input  wire logic        fuse_error_flag_in,
   input  wire logic        self_test_error_flag_in,
   input  wire logic        fuse_overvoltage_enable_default_in,
   input  wire logic        fuse_overvoltage_shutdown_default_in,
   input  wire logic [1:0]  fuse_overvoltage_debounce_default_in,
   input  wire logic        power_on_pin_sense_select_in,
   input  wire logic        power_on_request_pin_in,
   // Results
   output var  logic        overvoltage_interrupt_out,
   output var  logic        fuse_load_done_out,
   output var  logic        self_test_done_out,
   output var  logic        first_slot_start_out,
   output var  logic        power_down_start_out,
   output var  logic        low_power_off_disable_out
);
   localparam int W = ovq_pkg::CNT_W;

   ovq_pkg::ovq_state_t st_q;
   ovq_pkg::ovq_state_t st_d;

   logic [W-1:0] ov_lim;
   logic         mon_live;
   logic         ov_evt;
   logic         pon_evt;
   logic         pu_ok;
   logic         uv_rise;
   logic         acc;
   logic         ctrl_sel;
   logic         stat_sel;
   logic         ov_block;

   // ----------------------------------------------------------------
   // Debounce length select
   // ----------------------------------------------------------------
   always_comb begin
      unique case (st_q.dbnc_sel)
         ovq_pkg::DBNC_SHORT: ov_lim = W'(DBNC_SHORT_CYC - 1);
         ovq_pkg::DBNC_MID:   ov_lim = W'(DBNC_MID_CYC - 1);
         ovq_pkg::DBNC_LONG:  ov_lim = W'(DBNC_LONG_CYC - 1);
         default:             ov_lim = W'(DBNC_LONG_CYC - 1);
      endcase
   end

   // ----------------------------------------------------------------
   // Event qualification
   // ----------------------------------------------------------------
   always_comb begin
      // Monitor sleeps until the fuses are in, so a supply loss never leaves a stale count behind
      mon_live = st_q.mon_en && (st_q.mode != ovq_pkg::ST_UNPOWERED)
                 && (st_q.mode != ovq_pkg::ST_FUSE_LOAD);
      // Comparator must stay high over the whole window before one event fires
      ov_evt  = mon_live && overvoltage_cmp_in && !st_q.ov_hit
                && (st_q.ov_cnt == ov_lim);
      if (power_on_pin_sense_select_in) begin
         pon_evt = st_q.pon_armed && !power_on_request_pin_in
                   && (st_q.pon_cnt == W'(PON_DBNC_CYC - 1));
      end else begin
         pon_evt = power_on_request_pin_in;
      end
      // Overvoltage only blocks when monitored and the fuse asks for shutdown
      ov_block = overvoltage_cmp_in && st_q.mon_en && st_q.fuse_sdwn_def;
      pu_ok    = undervoltage_ok_in && !ov_block && !thermal_shutdown_in
                 && !trim_error_flag_in && !fuse_error_flag_in
                 && !self_test_error_flag_in;
      uv_rise  = undervoltage_ok_in && !st_q.uv_prev;
      acc      = (avs_read_in || avs_write_in) && !st_q.wreq;
      ctrl_sel = (avs_address_in == ovq_pkg::CTRL_OFS);
      stat_sel = (avs_address_in == ovq_pkg::STATUS_OFS);
   end

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb begin
      st_d            = st_q;
      st_d.uv_prev    = undervoltage_ok_in;
      st_d.pin_prev   = power_on_request_pin_in;
      st_d.first_slot = 1'b0;
      st_d.pwr_down   = 1'b0;

      // Overvoltage debounce counter, restarts on any dropout
      if (!mon_live || !overvoltage_cmp_in) begin
         st_d.ov_cnt = '0;
         st_d.ov_hit = 1'b0;
      end else if (ov_evt) begin
         st_d.ov_hit = 1'b1;
      end else if (!st_q.ov_hit) begin
         st_d.ov_cnt = st_q.ov_cnt + W'(1);
      end

      // Power-on pin edge mode: arm on falling edge, disarm on rise
      if (st_q.pin_prev && !power_on_request_pin_in) begin
         st_d.pon_armed = 1'b1;
         st_d.pon_cnt   = '0;
      end else if (power_on_request_pin_in || pon_evt) begin
         st_d.pon_armed = 1'b0;
         st_d.pon_cnt   = '0;
      end else if (st_q.pon_armed) begin
         st_d.pon_cnt = st_q.pon_cnt + W'(1);
      end

      // Sequencing
      unique case (st_q.mode)
         ovq_pkg::ST_UNPOWERED: begin
            st_d.fuse_done = 1'b0;
            st_d.test_done = 1'b0;
            if (uv_rise) begin
               st_d.mode   = ovq_pkg::ST_FUSE_LOAD;
               st_d.cnt    = '0;
               st_d.lp_dis = 1'b0;
            end
         end
         ovq_pkg::ST_FUSE_LOAD: begin
            st_d.cnt = st_q.cnt + W'(1);
            if (st_q.cnt == W'(FUSE_LOAD_CYC - 1)) begin
               st_d.mon_en        = fuse_overvoltage_enable_default_in;
               st_d.sdwn_sel      = fuse_overvoltage_shutdown_default_in;
               st_d.fuse_sdwn_def = fuse_overvoltage_shutdown_default_in;
               st_d.dbnc_sel      = fuse_overvoltage_debounce_default_in;
               st_d.fuse_done     = !fuse_error_flag_in;
               st_d.mode          = ovq_pkg::ST_OFF;
            end
         end
         ovq_pkg::ST_OFF: begin
            st_d.test_done = 1'b0;
            st_d.cnt       = '0;
            // Self-test always reruns from off; it fits both start budgets
            if (pon_evt && pu_ok) begin
               st_d.mode = ovq_pkg::ST_SELF_TEST;
            end
         end
         ovq_pkg::ST_SELF_TEST: begin
            st_d.cnt = st_q.cnt + W'(1);
            if (ov_evt && st_q.fuse_sdwn_def) begin
               st_d.mode = ovq_pkg::ST_OFF;
            end else if (st_q.cnt == W'(SELF_TEST_CYC - 1)) begin
               if (self_test_error_flag_in) begin
                  st_d.mode = ovq_pkg::ST_OFF;
               end else begin
                  st_d.test_done = 1'b1;
                  st_d.mode      = ovq_pkg::ST_START;
               end
            end
         end
         ovq_pkg::ST_START: begin
            if (ov_evt && st_q.fuse_sdwn_def) begin
               st_d.mode      = ovq_pkg::ST_OFF;
               st_d.test_done = 1'b0;
            end else begin
               st_d.first_slot = 1'b1;
               st_d.mode       = ovq_pkg::ST_RUN;
            end
         end
         ovq_pkg::ST_RUN: begin
            if (ov_evt && st_q.sdwn_sel) begin
               st_d.mode = ovq_pkg::ST_POWER_DN;
            end
         end
         ovq_pkg::ST_POWER_DN: begin
            st_d.pwr_down = 1'b1;
            st_d.mode     = ovq_pkg::ST_OFF;
         end
         default: begin
            st_d.mode = ovq_pkg::ST_UNPOWERED;
         end
      endcase

      // Supply loss drops everything back to unpowered
      if (!undervoltage_ok_in) begin
         st_d.mode = ovq_pkg::ST_UNPOWERED;
      end

      // Register bus: one wait cycle, then the access completes
      st_d.wreq = !((avs_read_in || avs_write_in) && st_q.wreq);
      if (avs_read_in && st_q.wreq) begin
         st_d.rdata = '0;
         if (ctrl_sel) begin
            st_d.rdata[ovq_pkg::CTRL_EN_BIT]   = st_q.mon_en;
            st_d.rdata[ovq_pkg::CTRL_SDWN_BIT] = st_q.sdwn_sel;
            st_d.rdata[ovq_pkg::CTRL_DBNC_LSB +: 2] = st_q.dbnc_sel;
            st_d.rdata[ovq_pkg::CTRL_LPDIS_BIT] = st_q.lp_dis;
         end else if (stat_sel) begin
            st_d.rdata[ovq_pkg::STAT_OVFLAG_BIT] = st_q.ov_flag;
            st_d.rdata[ovq_pkg::STAT_FUSE_BIT]   = st_q.fuse_done;
            st_d.rdata[ovq_pkg::STAT_TEST_BIT]   = st_q.test_done;
            st_d.rdata[ovq_pkg::STAT_OVLVL_BIT]  = st_q.ov_hit;
            st_d.rdata[ovq_pkg::STAT_STATE_LSB +: 3] = st_q.mode;
         end
      end
      if (acc && avs_write_in && avs_byteenable_in[0]) begin
         if (ctrl_sel && (st_q.mode != ovq_pkg::ST_UNPOWERED)
             && (st_q.mode != ovq_pkg::ST_FUSE_LOAD)) begin
            st_d.mon_en   = avs_writedata_in[ovq_pkg::CTRL_EN_BIT];
            st_d.sdwn_sel = avs_writedata_in[ovq_pkg::CTRL_SDWN_BIT];
            st_d.dbnc_sel = avs_writedata_in[ovq_pkg::CTRL_DBNC_LSB +: 2];
            // Only run mode may move it; it then holds until the next crossing
            if (st_q.mode == ovq_pkg::ST_RUN) begin
               st_d.lp_dis = avs_writedata_in[ovq_pkg::CTRL_LPDIS_BIT];
            end
         end
         if (stat_sel && avs_writedata_in[ovq_pkg::STAT_OVFLAG_BIT]) begin
            st_d.ov_flag = 1'b0;
         end
      end

      // Interrupt flag: a new event wins over a software clear in the same cycle, but not over supply loss
      if (ov_evt) begin
         if ((st_q.mode == ovq_pkg::ST_RUN) && !st_q.sdwn_sel) begin
            st_d.ov_flag = 1'b1;
         end
         if (((st_q.mode == ovq_pkg::ST_SELF_TEST) || (st_q.mode == ovq_pkg::ST_START))
             && !st_q.fuse_sdwn_def) begin
            st_d.ov_flag = 1'b1;
         end
      end
      if (!undervoltage_ok_in) begin
         st_d.ov_flag = 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------
   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         st_q <= '{wreq: 1'b1, mode: ovq_pkg::ST_UNPOWERED, default: '0};
      end else begin
         st_q <= st_d;
      end
   end

   assign avs_readdata_out          = st_q.rdata;
   assign avs_waitrequest_out       = st_q.wreq;
   assign overvoltage_interrupt_out = st_q.ov_flag;
   assign fuse_load_done_out        = st_q.fuse_done;
   assign self_test_done_out        = st_q.test_done;
   assign first_slot_start_out      = st_q.first_slot;
   assign power_down_start_out      = st_q.pwr_down;
   assign low_power_off_disable_out = st_q.lp_dis;
endmodule // ovq_qualifier
`default_nettype wire

// File: bench/ovq_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module ovq_host_model (
   input  wire logic       clk_in,
   input  wire logic       rstn_in,
   input  wire logic       level_in,
   input  wire logic       press_in,
   input  wire logic [7:0] hold_in,
   output var  logic       pin_out
);
   logic [7:0] low_q;
   // Slot fields stay at their defaults here; any extra regulator delay is the system's job
   // Press: drop the pin for hold_in cycles, then restore the level
   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) low_q <= 8'h00;
      else if (press_in) low_q <= hold_in;
      else if (low_q != 8'h00) low_q <= low_q - 8'h01;
   end
   assign pin_out = level_in && (low_q == 8'h00);
endmodule // ovq_host_model
`default_nettype wire

// File: bench/ovq_checker.sv
`timescale 1ns/1ps
`default_nettype none
module ovq_checker #(
   parameter int FUSE_LOAD_CYC = 10
) (
   input wire logic clk_in,
   input wire logic rstn_in,
   input wire logic avs_read_in,
   input wire logic avs_write_in,
   input wire logic avs_waitrequest_out,
   input wire logic undervoltage_ok_in,
   input wire logic overvoltage_cmp_in,
   input wire logic fuse_error_flag_in,
   input wire logic self_test_error_flag_in,
   input wire logic fuse_load_done_out,
   input wire logic self_test_done_out,
   input wire logic first_slot_start_out,
   input wire logic overvoltage_interrupt_out,
   input wire logic power_down_start_out,
   input wire logic low_power_off_disable_out
);
   localparam int FUSE_DLY = FUSE_LOAD_CYC + 1;
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!rstn_in);
   sequence s_answer;
      !avs_waitrequest_out ##1 avs_waitrequest_out;
   endsequence
   sequence s_slot;
      first_slot_start_out ##1 !first_slot_start_out;
   endsequence
   bus_answer_a: assert property ((avs_read_in || avs_write_in) && avs_waitrequest_out |=> s_answer)
      else $error("bus answer not one cycle later");
   slot_follow_a: assert property ($rose(self_test_done_out) |=> s_slot)
      else $error("first slot pulse missing after self test");
   test_pass_a: assert property ($rose(self_test_done_out) |-> !$past(self_test_error_flag_in) && fuse_load_done_out)
      else $error("self test done without a pass");
   fuse_time_a: assert property ($rose(undervoltage_ok_in) && !fuse_error_flag_in |-> ##[1:FUSE_DLY] fuse_load_done_out)
      else $error("fuse load done late");
   lpdis_clear_a: assert property ($rose(undervoltage_ok_in) |-> ##[1:2] !low_power_off_disable_out)
      else $error("low power off disable not cleared");
   irq_cause_a: assert property ($rose(overvoltage_interrupt_out) |-> $past(overvoltage_cmp_in) && $past(overvoltage_cmp_in, 4))
      else $error("interrupt without debounced overvoltage");
   pd_cause_a: assert property (power_down_start_out |-> $past(overvoltage_cmp_in, 2) && $past(overvoltage_cmp_in, 5) ##1 !power_down_start_out)
      else $error("power down start without debounced overvoltage");
   unpowered_a: assert property ($fell(undervoltage_ok_in) |-> ##[1:2] !self_test_done_out && !fuse_load_done_out)
      else $error("done flags kept while unpowered");
endmodule // ovq_checker
bind ovq_qualifier ovq_checker #(.FUSE_LOAD_CYC(FUSE_LOAD_CYC)) u_chk (.clk_in, .rstn_in, .avs_read_in,
   .avs_write_in, .avs_waitrequest_out, .undervoltage_ok_in, .overvoltage_cmp_in, .fuse_error_flag_in,
   .self_test_error_flag_in, .fuse_load_done_out, .self_test_done_out, .first_slot_start_out,
   .overvoltage_interrupt_out, .power_down_start_out, .low_power_off_disable_out);
`default_nettype wire

// File: bench/ovq_qualifier_test.sv
`timescale 1ns/1ps
`default_nettype none
module ovq_qualifier_test;
   localparam int FL = 10;
   localparam int ST = 10;
   localparam int PD = 5;
   logic        clk_in = 1'b0, rstn_in = 1'b0, rd = 1'b0, wr = 1'b0, uv = 1'b0, ov = 1'b0;
   logic        tsd = 1'b0, trim = 1'b0, ferr = 1'b0, sterr = 1'b0, fen = 1'b0, fsd = 1'b0;
   logic        sense = 1'b0, lvl = 1'b0, press = 1'b0, pin;
   logic [1:0]  fdb = 2'h0;
   logic [3:0]  addr = 4'h0;
   logic [7:0]  hold = 8'h00;
   logic [31:0] wdata = 32'h0, q, seed = 32'h3;
   logic [31:0] avs_readdata_out;
   logic        avs_waitrequest_out, lpd;
   wire logic [4:0] ob;
   int          n_errors = 0, num_checks = 0, i, n;
   initial forever #5 clk_in = ~clk_in;
   ovq_qualifier #(.DBNC_SHORT_CYC(4), .DBNC_MID_CYC(8), .DBNC_LONG_CYC(12), .FUSE_LOAD_CYC(FL),
      .SELF_TEST_CYC(ST), .PON_DBNC_CYC(PD)) dut (.clk_in, .rstn_in, .avs_address_in(addr),
      .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wdata), .avs_byteenable_in(4'hF),
      .avs_readdata_out, .avs_waitrequest_out, .undervoltage_ok_in(uv), .overvoltage_cmp_in(ov),
      .thermal_shutdown_in(tsd), .trim_error_flag_in(trim), .fuse_error_flag_in(ferr),
      .self_test_error_flag_in(sterr), .fuse_overvoltage_enable_default_in(fen),
      .fuse_overvoltage_shutdown_default_in(fsd), .fuse_overvoltage_debounce_default_in(fdb),
      .power_on_pin_sense_select_in(sense), .power_on_request_pin_in(pin),
      .overvoltage_interrupt_out(ob[3]), .fuse_load_done_out(ob[0]), .self_test_done_out(ob[1]),
      .first_slot_start_out(ob[2]), .power_down_start_out(ob[4]), .low_power_off_disable_out(lpd));
   ovq_host_model host (.clk_in, .rstn_in, .level_in(lvl), .press_in(press), .hold_in(hold), .pin_out(pin));
   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   function automatic int dl(input int c);
      return (c == 0) ? 4 : (c == 1) ? 8 : 12;
   endfunction
   task automatic test_done();
      $display("checks %0d errors %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("unexpected at %0t: got %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
      int k;
      @(posedge clk_in);
      addr <= a;
      wdata <= d;
      wr <= w;
      rd <= !w;
      for (k = 0; k < 50; k++) begin
         @(posedge clk_in);
         if (avs_waitrequest_out === 1'b0) break;
      end
      q = avs_readdata_out;
      rd <= 1'b0;
      wr <= 1'b0;
      if (k == 50) begin
         chk(32'h0, 32'h1);
         test_done();
      end
   endtask
   // Waits on one result bit; n returns lim + 1 when it never came
   task automatic wait_ob(input int k, input int lim, input logic must);
      for (n = 1; n <= lim; n++) begin
         @(posedge clk_in);
         if (ob[k] === 1'b1) break;
      end
      if (must && n > lim) begin
         chk(32'h0, 32'h1);
         test_done();
      end
   endtask
   task automatic pwr_cycle(input logic [3:0] fz);
      uv <= 1'b0;
      {fdb, fsd, fen} <= fz;
      repeat (3) @(posedge clk_in);
      uv <= 1'b1;
      wait_ob(0, FL + 5, !ferr);
      chk(32'(ferr ? n > FL + 5 : n <= FL + 3), 32'h1);
      chk(32'(lpd), 32'h0);
   endtask
   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      repeat (2) @(posedge clk_in);
      rstn_in <= 1'b1;
      for (i = 0; i < 4; i++) begin
         pwr_cycle(4'(rnd()));
         bus(1'b0, 4'h0, 32'h0);
         chk(32'(q[4:0]), {28'h0, fdb, fsd, fen});
         bus(1'b0, 4'h4, 32'h0);
         chk(32'(q[6:4]), 32'h3);
      end
      lvl <= 1'b1;
      wait_ob(1, ST + 8, 1'b1);
      chk(32'(n <= ST + 4), 32'h1);
      wait_ob(2, 3, 1'b1);
      chk(n, 32'h1);
      bus(1'b1, 4'h0, 32'h11);
      bus(1'b0, 4'h0, 32'h0);
      chk({q[4], lpd}, 32'h3);
      bus(1'b1, 4'h8, rnd());
      bus(1'b0, 4'h8, 32'h0);
      chk(q, 32'h0);
      for (i = 0; i < 4; i++) begin
         bus(1'b1, 4'h0, {27'h0, 1'b1, 2'(i), 2'h1});
         ov <= 1'b1;
         repeat (2) @(posedge clk_in);
         ov <= 1'b0;
         wait_ob(3, 20, 1'b0);
         chk(n, 32'd21);
         ov <= 1'b1;
         wait_ob(3, 30, 1'b1);
         chk(32'(n >= dl(i) + 1 && n <= dl(i) + 4), 32'h1);
         ov <= 1'b0;
         chk(32'(ob[1]), 32'h1);
         bus(1'b1, 4'h4, 32'h1);
         bus(1'b0, 4'h4, 32'h0);
         chk(32'(q[0]), 32'h0);
      end
      bus(1'b1, 4'h0, 32'h10);
      ov <= 1'b1;
      wait_ob(3, 30, 1'b0);
      chk(n, 32'd31);
      bus(1'b1, 4'h0, 32'h13);
      wait_ob(4, 20, 1'b1);
      ov <= 1'b0;
      repeat (8) @(posedge clk_in);
      chk(32'(ob[1]), 32'h0);
      lvl <= 1'b0;
      pwr_cycle(4'h3);
      lvl <= 1'b1;
      @(posedge clk_in);
      ov <= 1'b1;
      wait_ob(1, 40, 1'b0);
      chk(n, 32'd41);
      lvl <= 1'b0;
      pwr_cycle(4'h1);
      lvl <= 1'b1;
      wait_ob(2, 40, 1'b1);
      wait_ob(3, 30, 1'b1);
      ov <= 1'b0;
      for (i = 0; i < 4; i++) begin
         {tsd, trim, ferr, sterr} <= 4'h1 << i;
         lvl <= 1'b0;
         pwr_cycle(4'h1);
         lvl <= 1'b1;
         wait_ob(1, 40, 1'b0);
         chk(n, 32'd41);
      end
      {tsd, trim, ferr, sterr} <= 4'h0;
      sense <= 1'b1;
      pwr_cycle(4'h1);
      for (i = 0; i < 2; i++) begin
         hold <= (i == 0) ? 8'h02 : 8'(PD + 3);
         press <= 1'b1;
         @(posedge clk_in);
         press <= 1'b0;
         wait_ob(1, 40, 1'(i));
         chk(32'(n <= 40), 32'(i));
      end
      test_done();
   end
endmodule // ovq_qualifier_test
`default_nettype wire
